/* rtl/pulse_measure_params.svh */
// Register map, reset values and timing counts for one measurement channel
// Overview of operation
// - Interval check; fixed value reported on timeout
// - Level-dependent modes report measured line level
// - Angle check once per 720 degree cycle
// - Combined modes: either failed check is timeout
// - Default value used only in fixed modes
// - Interval/check point used only where relevant
// - Angle window applies only in synchronous mode
// - Additive window counts published at upper window limit in synchronous mode
// - Pulse parameter: n-th index or maximum count
// - Angle results relative to reference angle
// - Input line chosen from sixteen by field
// - Mode bit: asynchronous or angle synchronous
// - Reference: none, input line, or channel
// - Edge angle capture codes 14,15,30,31
// - Pulse count codes 16,17,40,41
// - Stepper step count codes 42 and 63
// - Enable-to-n-th-edge time codes 43 to 46
// - Timeout interval never below 1 ms
// - Timeout status 0 none, 1 hit, 2 off
// - Unused channel reports -8888
`ifndef PULSE_MEASURE_PARAMS_SVH
`define PULSE_MEASURE_PARAMS_SVH
`define OFS_CFG       8'h00
`define OFS_TOUT      8'h04
`define OFS_DEFVAL    8'h08
`define OFS_INTERVAL  8'h0c
`define OFS_CHECKPT   8'h10
`define OFS_LOWER     8'h14
`define OFS_UPPER     8'h18
`define OFS_REFANG    8'h1c
`define OFS_PULSES    8'h20
`define OFS_STATUS    8'h24
`define OFS_RESULT    8'h28
`define RST_CFG       32'hff0000ff
`define CLK_PERIOD_NS 10
`define MS_NS         1000000
`define US_NS         1000
`define CYC_PER_MS    (`MS_NS / `CLK_PERIOD_NS)
`define CYC_PER_US    (`US_NS / `CLK_PERIOD_NS)
`define DEG_CYCLE     16'sh02d0
`define MIN_INTVL_MS  16'h0001
`define NO_MEAS_VALUE 32'hffffdd48
`endif

/* rtl/pulse_measure_pkg.sv */
// Types shared by the measurement channel
package pulse_measure_pkg;
  typedef logic [9:0]        angle_t;
  typedef logic signed [15:0] sangle_t;
  typedef struct packed {
    logic signed [7:0] ref_chan;
    logic [6:0]        rsvd;
    logic              angle_sync_mode;
    logic signed [7:0] line;
    logic signed [7:0] proc;
  } chan_cfg_t;
  typedef enum logic [2:0] {
    tout_off_mode             = 3'h0,
    interval_fixed_mode       = 3'h1,
    interval_level_value_mode = 3'h2,
    angle_fixed_mode          = 3'h3,
    angle_level_value_mode    = 3'h4,
    combined_fixed_mode       = 3'h5,
    combined_level_value_mode = 3'h6
  } tout_mode_t;
  typedef enum logic [1:0] {
    tout_none     = 2'h0,
    tout_hit      = 2'h1,
    tout_inactive = 2'h2
  } tout_stat_t;
  typedef enum logic [7:0] {
    proc_rise_ang   = 8'h0e,
    proc_fall_ang   = 8'h0f,
    proc_win_low    = 8'h10,
    proc_win_high   = 8'h11,
    proc_nth_rise   = 8'h1e,
    proc_nth_fall   = 8'h1f,
    proc_tot_low    = 8'h28,
    proc_tot_high   = 8'h29,
    proc_step_a     = 8'h2a,
    proc_en_nrise   = 8'h2b,
    proc_en_nfall   = 8'h2c,
    proc_low_en     = 8'h2d,
    proc_high_en    = 8'h2e,
    proc_step_b     = 8'h3f
  } proc_t;
endpackage : pulse_measure_pkg

/* rtl/pulse_measure_channel_config.sv */
// One pulse measurement channel with configuration and timeout supervision
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "pulse_measure_params.svh"
module pulse_measure_channel_config #(
  parameter int unsigned CYC_PER_MS = `CYC_PER_MS,
  parameter int unsigned CYC_PER_US = `CYC_PER_US
) (
  input  wire logic                      core_clk_i,    // Clock
  input  wire logic                      rst_b_i,       // Sync reset, low
  input  wire logic [7:0]                addr_i,        // Register byte address
  input  wire logic [31:0]               wr_data_i,     // Write data
  input  wire logic                      wr_en_i,       // Write strobe
  input  wire logic                      rd_en_i,       // Read strobe
  output logic [31:0]                    rd_data_o,     // Read data, next cycle
  input  wire logic [15:0]               lines_i,       // Measured input lines
  input  wire logic [31:0]               peer_level_i,  // Other channel levels
  input  wire pulse_measure_pkg::angle_t crank_angle_i, // Crank angle 0..719
  output logic [31:0]                    result_o,      // Measurement value
  output logic                           update_o,      // Value updated flag
  output logic [1:0]                     tout_status_o  // Timeout status
);
  import pulse_measure_pkg::*;

  chan_cfg_t  cfg_reg,    cfg_next;
  tout_mode_t tmode_reg,  tmode_next;
  logic [31:0] defval_reg, defval_next;
  logic [15:0] intvl_reg,  intvl_next;
  sangle_t    chk_reg,    chk_next;
  sangle_t    low_reg,    low_next;
  sangle_t    up_reg,     up_next;
  sangle_t    refa_reg,   refa_next;
  logic [31:0] npulse_reg, npulse_next;
  logic [31:0] rd_reg,     rd_next;

  logic       line_q_reg, line_q_next;
  logic       en_q_reg,   en_q_next;
  angle_t     ang_q_reg,  ang_q_next;
  logic [31:0] ms_pre_reg, ms_pre_next;
  logic [31:0] us_pre_reg, us_pre_next;
  logic [15:0] ms_cnt_reg, ms_cnt_next;
  logic [31:0] cnt_reg,    cnt_next;
  logic [31:0] acc_reg,    acc_next;
  logic       armed_reg,  armed_next;
  logic       done_reg,   done_next;
  logic       seen_i_reg, seen_i_next;
  logic       seen_a_reg, seen_a_next;
  logic [31:0] res_reg,    res_next;
  logic       upd_reg,    upd_next;
  tout_stat_t tstat_reg,  tstat_next;

  logic       sel, rise, fall, refl, en, edge_hit;
  logic       win, ang_step, at_low, at_up, at_chk;
  logic       ms_tick, us_tick, has_i, has_a, predef;
  logic       chk_i, chk_a, fail, meas_evt, active;
  logic [31:0] meas_val, cnt_inc;
  logic [15:0] intvl_eff;
  angle_t     rel_now;

  function automatic angle_t norm_ang(input sangle_t a);
    sangle_t t;
    t = a;
    if (t < 0) begin
      t = t + `DEG_CYCLE;
    end else if (t >= `DEG_CYCLE) begin
      t = t - `DEG_CYCLE;
    end
    return angle_t'(t);
  endfunction : norm_ang

  function automatic logic in_win(input angle_t a, input angle_t lo,
                                  input angle_t hi);
    if (lo <= hi) begin
      return (a >= lo) && (a <= hi);
    end
    return (a >= lo) || (a <= hi);
  endfunction : in_win

  function automatic logic ref_level(input logic signed [7:0] r,
                                     input logic [15:0] ln,
                                     input logic [31:0] pl);
    logic [7:0] idx;
    idx = 8'(r - 8'sh10);
    if (r < 0) begin
      return 1'b0;
    end else if (r < 8'sh10) begin
      return ln[r[3:0]];
    end else if (r < 8'sh30) begin
      return pl[idx[4:0]];
    end
    return 1'b0;
  endfunction : ref_level

  // Configuration registers and read port
  always_comb begin
    cfg_next    = cfg_reg;
    tmode_next  = tmode_reg;
    defval_next = defval_reg;
    intvl_next  = intvl_reg;
    chk_next    = chk_reg;
    low_next    = low_reg;
    up_next     = up_reg;
    refa_next   = refa_reg;
    npulse_next = npulse_reg;
    rd_next     = 32'h0;
    if (wr_en_i) begin
      if (addr_i == `OFS_CFG) begin
        cfg_next      = chan_cfg_t'(wr_data_i);
        cfg_next.rsvd = 7'h0;
      end else if (addr_i == `OFS_TOUT) begin
        tmode_next = tout_mode_t'(wr_data_i[2:0]);
      end else if (addr_i == `OFS_DEFVAL) begin
        defval_next = wr_data_i;
      end else if (addr_i == `OFS_INTERVAL) begin
        intvl_next = wr_data_i[15:0];
      end else if (addr_i == `OFS_CHECKPT) begin
        chk_next = wr_data_i[15:0];
      end else if (addr_i == `OFS_LOWER) begin
        low_next = wr_data_i[15:0];
      end else if (addr_i == `OFS_UPPER) begin
        up_next = wr_data_i[15:0];
      end else if (addr_i == `OFS_REFANG) begin
        refa_next = wr_data_i[15:0];
      end else if (addr_i == `OFS_PULSES) begin
        npulse_next = wr_data_i;
      end
    end
    if (rd_en_i) begin
      if (addr_i == `OFS_CFG) begin
        rd_next = cfg_reg;
      end else if (addr_i == `OFS_TOUT) begin
        rd_next = {29'h0, tmode_reg};
      end else if (addr_i == `OFS_DEFVAL) begin
        rd_next = defval_reg;
      end else if (addr_i == `OFS_INTERVAL) begin
        rd_next = {16'h0, intvl_reg};
      end else if (addr_i == `OFS_CHECKPT) begin
        rd_next = {16'h0, chk_reg};
      end else if (addr_i == `OFS_LOWER) begin
        rd_next = {16'h0, low_reg};
      end else if (addr_i == `OFS_UPPER) begin
        rd_next = {16'h0, up_reg};
      end else if (addr_i == `OFS_REFANG) begin
        rd_next = {16'h0, refa_reg};
      end else if (addr_i == `OFS_PULSES) begin
        rd_next = npulse_reg;
      end else if (addr_i == `OFS_STATUS) begin
        rd_next = {28'h0, win, upd_reg, tstat_reg};
      end else if (addr_i == `OFS_RESULT) begin
        rd_next = res_reg;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      cfg_reg    <= chan_cfg_t'(`RST_CFG);
      tmode_reg  <= tout_off_mode;
      defval_reg <= 32'h0;
      intvl_reg  <= `MIN_INTVL_MS;
      chk_reg    <= 16'h0;
      low_reg    <= 16'h0;
      up_reg     <= 16'h0;
      refa_reg   <= 16'h0;
      npulse_reg <= 32'h0;
      rd_reg     <= 32'h0;
    end else begin
      cfg_reg    <= cfg_next;
      tmode_reg  <= tmode_next;
      defval_reg <= defval_next;
      intvl_reg  <= intvl_next;
      chk_reg    <= chk_next;
      low_reg    <= low_next;
      up_reg     <= up_next;
      refa_reg   <= refa_next;
      npulse_reg <= npulse_next;
      rd_reg     <= rd_next;
    end
  end

  // Input selection, angle events and time bases
  always_comb begin
    sel      = lines_i[cfg_reg.line[3:0]];
    rise     = sel & ~line_q_reg;
    fall     = ~sel & line_q_reg;
    refl     = ref_level(cfg_reg.ref_chan, lines_i, peer_level_i);
    ang_step = crank_angle_i != ang_q_reg;
    at_low   = ang_step && (crank_angle_i == norm_ang(low_reg));
    at_up    = ang_step && (crank_angle_i == norm_ang(up_reg));
    at_chk   = ang_step && (crank_angle_i == norm_ang(chk_reg));
    win      = !cfg_reg.angle_sync_mode ||
               in_win(crank_angle_i, norm_ang(low_reg), norm_ang(up_reg));
    rel_now  = norm_ang(sangle_t'({6'h0, crank_angle_i}) -
                        sangle_t'({6'h0, norm_ang(refa_reg)}));
    ms_tick  = ms_pre_reg == CYC_PER_MS - 1;
    us_tick  = us_pre_reg == CYC_PER_US - 1;
    intvl_eff = (intvl_reg < `MIN_INTVL_MS) ? `MIN_INTVL_MS : intvl_reg;
    cnt_inc  = cnt_reg + 32'h1;
    has_i    = (tmode_reg == interval_fixed_mode) || (tmode_reg == interval_level_value_mode) ||
               (tmode_reg == combined_fixed_mode) || (tmode_reg == combined_level_value_mode);
    has_a    = (tmode_reg == angle_fixed_mode) || (tmode_reg == angle_level_value_mode) ||
               (tmode_reg == combined_fixed_mode) || (tmode_reg == combined_level_value_mode);
    predef   = (tmode_reg == interval_fixed_mode) || (tmode_reg == angle_fixed_mode) ||
               (tmode_reg == combined_fixed_mode);
    en       = (proc_t'(cfg_reg.proc) == proc_low_en) ? ~refl : refl;
    edge_hit = (proc_t'(cfg_reg.proc) == proc_en_nfall) ? fall : rise;
  end

  // Measurement procedures and timeout supervision
  always_comb begin
    line_q_next = sel;
    en_q_next   = en;
    ang_q_next  = crank_angle_i;
    ms_pre_next = ms_tick ? 32'h0 : ms_pre_reg + 32'h1;
    us_pre_next = us_tick ? 32'h0 : us_pre_reg + 32'h1;
    cnt_next    = cnt_reg;
    acc_next    = acc_reg;
    armed_next  = armed_reg;
    done_next   = done_reg;
    meas_evt    = 1'b0;
    meas_val    = res_reg;
    active      = 1'b1;
    if (at_low) begin
      done_next = 1'b0;
    end
    case (proc_t'(cfg_reg.proc))
      proc_rise_ang, proc_fall_ang: begin
        if (((proc_t'(cfg_reg.proc) == proc_rise_ang) ? rise : fall) && win &&
            !(cfg_reg.angle_sync_mode && done_reg)) begin
          meas_evt  = 1'b1;
          meas_val  = {22'h0, rel_now};
          done_next = 1'b1;
        end
      end
      proc_nth_rise, proc_nth_fall: begin
        if (at_low) begin
          cnt_next = 32'h0;
        end
        if (((proc_t'(cfg_reg.proc) == proc_nth_rise) ? rise : fall) && win) begin
          cnt_next = cnt_inc;
          if ((npulse_reg == 32'h0) || (cnt_inc == npulse_reg)) begin
            meas_evt = 1'b1;
            meas_val = {22'h0, rel_now};
          end
        end
      end
      proc_win_low, proc_win_high, proc_tot_low, proc_tot_high: begin
        if (((proc_t'(cfg_reg.proc) == proc_win_low) ||
             (proc_t'(cfg_reg.proc) == proc_tot_low) ? rise : fall) &&
            ((proc_t'(cfg_reg.proc) == proc_tot_low) ||
             (proc_t'(cfg_reg.proc) == proc_tot_high) || win) &&
            ((npulse_reg == 32'h0) || (cnt_reg < npulse_reg))) begin
          cnt_next = cnt_inc;
          if ((proc_t'(cfg_reg.proc) == proc_tot_low) ||
              (proc_t'(cfg_reg.proc) == proc_tot_high) ||
              !cfg_reg.angle_sync_mode) begin
            meas_evt = 1'b1;
            meas_val = cnt_inc;
          end
        end
        if (at_up && cfg_reg.angle_sync_mode &&
            ((proc_t'(cfg_reg.proc) == proc_win_low) ||
             (proc_t'(cfg_reg.proc) == proc_win_high))) begin
          meas_evt = 1'b1;
          meas_val = cnt_reg;
          cnt_next = 32'h0;
        end
      end
      proc_step_a, proc_step_b: begin
        if (rise && win) begin
          cnt_next = refl ? cnt_reg - 32'h1 : cnt_inc;
          meas_evt = 1'b1;
          meas_val = cnt_next;
        end
      end
      proc_en_nrise, proc_en_nfall, proc_low_en, proc_high_en: begin
        if (en && !en_q_reg) begin
          armed_next = 1'b1;
          acc_next   = 32'h0;
          cnt_next   = 32'h0;
        end else if (armed_reg) begin
          if (us_tick) begin
            acc_next = acc_reg + 32'h1;
          end
          if (edge_hit && win) begin
            cnt_next = cnt_inc;
            if (cnt_inc >= npulse_reg) begin
              meas_evt   = 1'b1;
              meas_val   = acc_reg;
              armed_next = 1'b0;
            end
          end
        end
      end
      default: begin
        active = 1'b0;
      end
    endcase
    if (wr_en_i && (addr_i == `OFS_CFG)) begin
      cnt_next = 32'h0;
    end
  end

  always_comb begin
    chk_i       = 1'b0;
    chk_a       = has_a && at_chk;
    ms_cnt_next = has_i ? ms_cnt_reg : 16'h0;
    if (has_i && ms_tick) begin
      if (ms_cnt_reg + 16'h1 >= intvl_eff) begin
        ms_cnt_next = 16'h0;
        chk_i       = 1'b1;
      end else begin
        ms_cnt_next = ms_cnt_reg + 16'h1;
      end
    end
    seen_i_next = seen_i_reg | meas_evt;
    seen_a_next = seen_a_reg | meas_evt;
    fail        = (chk_i && !seen_i_next) || (chk_a && !seen_a_next);
    if (chk_i) begin
      seen_i_next = 1'b0;
    end
    if (chk_a) begin
      seen_a_next = 1'b0;
    end
    res_next   = res_reg;
    tstat_next = tstat_reg;
    upd_next   = upd_reg && !(rd_en_i && (addr_i == `OFS_RESULT));
    if (!active) begin
      res_next   = `NO_MEAS_VALUE;
      tstat_next = tout_inactive;
    end else if (meas_evt) begin
      res_next   = meas_val;
      upd_next   = 1'b1;
      tstat_next = (has_i || has_a) ? tout_none : tout_inactive;
    end else if (fail) begin
      res_next   = predef ? defval_reg : {31'h0, sel};
      upd_next   = 1'b1;
      tstat_next = tout_hit;
    end else if (!(has_i || has_a)) begin
      tstat_next = tout_inactive;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      line_q_reg <= 1'b0;
      en_q_reg   <= 1'b0;
      ang_q_reg  <= 10'h0;
      ms_pre_reg <= 32'h0;
      us_pre_reg <= 32'h0;
      ms_cnt_reg <= 16'h0;
      cnt_reg    <= 32'h0;
      acc_reg    <= 32'h0;
      armed_reg  <= 1'b0;
      done_reg   <= 1'b0;
      seen_i_reg <= 1'b0;
      seen_a_reg <= 1'b0;
      res_reg    <= `NO_MEAS_VALUE;
      upd_reg    <= 1'b0;
      tstat_reg  <= tout_inactive;
    end else begin
      line_q_reg <= line_q_next;
      en_q_reg   <= en_q_next;
      ang_q_reg  <= ang_q_next;
      ms_pre_reg <= ms_pre_next;
      us_pre_reg <= us_pre_next;
      ms_cnt_reg <= ms_cnt_next;
      cnt_reg    <= cnt_next;
      acc_reg    <= acc_next;
      armed_reg  <= armed_next;
      done_reg   <= done_next;
      seen_i_reg <= seen_i_next;
      seen_a_reg <= seen_a_next;
      res_reg    <= res_next;
      upd_reg    <= upd_next;
      tstat_reg  <= tstat_next;
    end
  end

  assign rd_data_o     = rd_reg;
  assign result_o      = res_reg;
  assign update_o      = upd_reg;
  assign tout_status_o = tstat_reg;
endmodule : pulse_measure_channel_config
`default_nettype wire

/* bench/pulse_measure_channel_config_checker.sv */
// Port-level assertions for the measurement channel
`timescale 1ns/10ps
`default_nettype none
`include "pulse_measure_params.svh"
module pulse_measure_channel_config_checker
  import pulse_measure_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = 20,
  parameter int unsigned CYC_PER_US = 4
) (
  input wire logic                      core_clk_i,    // Clock
  input wire logic                      rst_b_i,       // Reset, low
  input wire logic [7:0]                addr_i,        // Address
  input wire logic [31:0]               wr_data_i,     // Write data
  input wire logic                      wr_en_i,       // Write strobe
  input wire logic                      rd_en_i,       // Read strobe
  input wire logic [31:0]               rd_data_o,     // Read data
  input wire logic [15:0]               lines_i,       // Lines
  input wire logic [31:0]               peer_level_i,  // Peer levels
  input wire pulse_measure_pkg::angle_t crank_angle_i, // Angle
  input wire logic [31:0]               result_o,      // Result
  input wire logic                      update_o,      // Update flag
  input wire logic [1:0]                tout_status_o  // Timeout status
);
  logic [31:0] run_reg;
  logic [31:0] run_next;

  default clocking @(posedge core_clk_i); endclocking

  // Cycles since reset release, saturating
  always_comb begin
    run_next = run_reg;
    if (!rst_b_i) begin
      run_next = 32'h0;
    end else if (run_reg < CYC_PER_MS) begin
      run_next = run_reg + 32'h1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    run_reg <= run_next;
  end

  sequence s_rd_status;
    rd_en_i && addr_i == `OFS_STATUS;
  endsequence
  sequence s_rd_cfg;
    rd_en_i && addr_i == `OFS_CFG;
  endsequence
  sequence s_new_hit;
    tout_status_o == tout_hit && $past(tout_status_o) != tout_hit;
  endsequence

  AST_RESET_VALUES: assert property (!rst_b_i |=> result_o == `NO_MEAS_VALUE
    && tout_status_o == tout_inactive && !update_o && rd_data_o == 32'h0)
    else $error("reset outputs wrong");
  AST_STATUS_CODE: assert property (disable iff (!rst_b_i) tout_status_o != 2'h3)
    else $error("illegal timeout status");
  AST_HIT_SETS_UPDATE: assert property (disable iff (!rst_b_i) s_new_hit |-> update_o)
    else $error("timeout without update");
  AST_STATUS_READ: assert property (disable iff (!rst_b_i) s_rd_status |=>
    rd_data_o[1:0] == $past(tout_status_o) && rd_data_o[2] == $past(update_o))
    else $error("status read mismatch");
  AST_CFG_RSVD: assert property (disable iff (!rst_b_i) s_rd_cfg |=> rd_data_o[23:17] == 7'h0)
    else $error("reserved cfg bits set");
  AST_READ_IDLE: assert property (disable iff (!rst_b_i) !rd_en_i |=> rd_data_o == 32'h0)
    else $error("read data outside read cycle");
  AST_MIN_INTERVAL: assert property (disable iff (!rst_b_i)
    tout_status_o == tout_hit |-> run_reg >= CYC_PER_MS - 1)
    else $error("timeout sooner than one interval");
  AST_CHANGE_UPDATE: assert property (disable iff (!rst_b_i) $changed(result_o)
    && !$past(wr_en_i) && !$past(wr_en_i, 2) && !$past(wr_en_i, 3) |-> update_o)
    else $error("result changed without update");
  AST_UPDATE_STICKY: assert property (disable iff (!rst_b_i) $fell(update_o) |->
    $past(rd_en_i && addr_i == `OFS_RESULT) || $past(rd_en_i && addr_i == `OFS_RESULT, 2))
    else $error("update cleared without read");
endmodule : pulse_measure_channel_config_checker

bind pulse_measure_channel_config pulse_measure_channel_config_checker #(
  .CYC_PER_MS(CYC_PER_MS),
  .CYC_PER_US(CYC_PER_US)
) checker_inst (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .lines_i(lines_i),
  .peer_level_i(peer_level_i), .crank_angle_i(crank_angle_i), .result_o(result_o),
  .update_o(update_o), .tout_status_o(tout_status_o)
);
`default_nettype wire

/* bench/pulse_source_model.sv */
// Behavioural controller lines, peer levels and crank angle source
`timescale 1ns/10ps
`default_nettype none
module pulse_source_model (
  input  wire logic                 clk_i,   // Clock
  output logic [15:0]               lines_o, // Measured lines
  output logic [31:0]               peer_o,  // Peer channel levels
  output pulse_measure_pkg::angle_t angle_o  // Crank angle
);
  import pulse_measure_pkg::*;
  angle_t      cur;
  logic [15:0] ln_q;
  logic [31:0] pr_q;
  angle_t      an_q;

  initial begin
    ln_q = 16'h0;
    pr_q = 32'h0;
    an_q = 10'h0;
    cur = 10'h0;
  end

  always_comb begin
    lines_o = ln_q;
    peer_o  = pr_q;
    angle_o = an_q;
  end

  task set_line(input int i, input logic v);
    @(posedge clk_i);
    ln_q[i] <= v;
  endtask : set_line

  // Level v held four cycles, then back
  task pulse(input int i, input logic v);
    set_line(i, v);
    repeat (3) @(posedge clk_i);
    set_line(i, ~v);
    repeat (3) @(posedge clk_i);
  endtask : pulse

  task set_peer(input int i, input logic v);
    @(posedge clk_i);
    pr_q[i] <= v;
  endtask : set_peer

  // One degree per cycle, wrapping after 719
  task step_to(input angle_t a);
    while (cur != a) begin
      cur = (cur == 10'h2cf) ? 10'h0 : cur + 10'h1;
      @(posedge clk_i);
      an_q <= cur;
    end
  endtask : step_to
endmodule : pulse_source_model
`default_nettype wire

/* bench/test_pulse_measure_channel_config.sv */
// Self-checking bench for the measurement channel
`timescale 1ns/10ps
`default_nettype none
`include "pulse_measure_params.svh"
module test_pulse_measure_channel_config;
  import pulse_measure_pkg::*;
  localparam int MS = 20;
  logic        core_clk_i;
  logic        rst_b_i;
  logic        wr_en_i;
  logic        rd_en_i;
  logic [7:0]  addr_i;
  logic [31:0] wr_data_i;
  logic [31:0] rd_data_o;
  logic [31:0] peer_level_i;
  logic [31:0] result_o;
  logic [31:0] rdv;
  logic [15:0] lines_i;
  angle_t      crank_angle_i;
  logic        update_o;
  logic [1:0]  tout_status_o;
  int          bad_count;
  int          n_tests;
  int          cyc;

  pulse_measure_channel_config #(.CYC_PER_MS(MS), .CYC_PER_US(4))
    pulse_measure_channel_config_inst (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .lines_i(lines_i),
    .peer_level_i(peer_level_i), .crank_angle_i(crank_angle_i), .result_o(result_o),
    .update_o(update_o), .tout_status_o(tout_status_o));
  pulse_source_model pulse_source_model_inst (
    .clk_i(core_clk_i), .lines_o(lines_i), .peer_o(peer_level_i), .angle_o(crank_angle_i));

  task final_report;
    $display("mismatches %0d comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task chk_v(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_v

  task chk_s(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t flag %h expected %h", $time, got, exp);
    end
  endtask : chk_s

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge core_clk_i);
    wr_en_i <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge core_clk_i);
    rd_en_i <= 1'b0;
    #1 d = rd_data_o;
  endtask : rd

  task tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      final_report;
    end
  end

  initial begin
    rst_b_i = 1'b0;
    addr_i = 8'h0;
    wr_data_i = 32'h0;
    wr_en_i = 1'b0;
    rd_en_i = 1'b0;
    bad_count = 0;
    n_tests = 0;
    cyc = 0;
    repeat (16) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    tick(1);
    chk_v(result_o, `NO_MEAS_VALUE);
    chk_s(tout_status_o, tout_inactive);
    rd(`OFS_CFG, rdv);
    chk_v(rdv, `RST_CFG);
    rd(8'h30, rdv);
    chk_v(rdv, 32'h0);
    // Total high pulses, line 4 ignored
    wr(`OFS_CFG, 32'hff000329);
    pulse_source_model_inst.pulse(3, 1'b1);
    pulse_source_model_inst.pulse(3, 1'b1);
    pulse_source_model_inst.pulse(4, 1'b1);
    tick(2);
    chk_v(result_o, 32'h2);
    chk_s({1'b0, update_o}, 2'h1);
    rd(`OFS_RESULT, rdv);
    chk_v(rdv, 32'h2);
    tick(2);
    chk_s({1'b0, update_o}, 2'h0);
    // Edge angles from reference 50
    wr(`OFS_REFANG, 32'h32);
    wr(`OFS_CFG, 32'hff00030e);
    pulse_source_model_inst.step_to(10'hc8);
    pulse_source_model_inst.pulse(3, 1'b1);
    tick(2);
    chk_v(result_o, 32'h96);
    wr(`OFS_PULSES, 32'h2);
    wr(`OFS_CFG, 32'hff00031e);
    pulse_source_model_inst.pulse(3, 1'b1);
    pulse_source_model_inst.step_to(10'hd2);
    pulse_source_model_inst.pulse(3, 1'b1);
    pulse_source_model_inst.step_to(10'hdc);
    pulse_source_model_inst.pulse(3, 1'b1);
    tick(2);
    chk_v(result_o, 32'ha0);
    wr(`OFS_CFG, 32'hff00030f);
    pulse_source_model_inst.step_to(10'h0a);
    pulse_source_model_inst.pulse(3, 1'b1);
    tick(2);
    chk_v(result_o, 32'h2a8);
    // Stepper A, reference channel 0
    wr(`OFS_CFG, 32'h1000032a);
    pulse_source_model_inst.set_peer(0, 1'b1);
    pulse_source_model_inst.pulse(3, 1'b1);
    pulse_source_model_inst.pulse(3, 1'b1);
    tick(2);
    chk_v(result_o, 32'hfffffffe);
    pulse_source_model_inst.set_peer(0, 1'b0);
    pulse_source_model_inst.pulse(3, 1'b1);
    tick(2);
    chk_v(result_o, 32'hffffffff);
    // Windowed low pulses, window 100..300
    wr(`OFS_LOWER, 32'h64);
    wr(`OFS_UPPER, 32'h12c);
    wr(`OFS_CFG, 32'hff010310);
    pulse_source_model_inst.set_line(3, 1'b1);
    pulse_source_model_inst.step_to(10'h96);
    pulse_source_model_inst.pulse(3, 1'b0);
    pulse_source_model_inst.pulse(3, 1'b0);
    pulse_source_model_inst.step_to(10'h12c);
    tick(2);
    chk_v(result_o, 32'h2);
    pulse_source_model_inst.step_to(10'h15e);
    pulse_source_model_inst.pulse(3, 1'b0);
    pulse_source_model_inst.step_to(10'h12c);
    tick(2);
    chk_v(result_o, 32'h0);
    pulse_source_model_inst.set_line(3, 1'b0);
    // Interval timeout, fixed value
    wr(`OFS_DEFVAL, 32'h12345678);
    wr(`OFS_INTERVAL, 32'h1);
    wr(`OFS_CFG, 32'hff000329);
    wr(`OFS_TOUT, 32'h1);
    tick(3 * MS);
    chk_v(result_o, 32'h12345678);
    chk_s(tout_status_o, tout_hit);
    chk_s({1'b0, update_o}, 2'h1);
    rd(`OFS_STATUS, rdv);
    chk_v(rdv, 32'hd);
    pulse_source_model_inst.pulse(3, 1'b1);
    tick(2);
    chk_s(tout_status_o, tout_none);
    // Level-dependent value
    wr(`OFS_TOUT, 32'h2);
    pulse_source_model_inst.set_line(3, 1'b1);
    tick(3 * MS);
    chk_v(result_o, 32'h1);
    pulse_source_model_inst.set_line(3, 1'b0);
    // Angle check only, interval ignored
    wr(`OFS_CHECKPT, 32'h64);
    wr(`OFS_TOUT, 32'h3);
    pulse_source_model_inst.pulse(3, 1'b1);
    tick(3 * MS);
    chk_s(tout_status_o, tout_none);
    pulse_source_model_inst.step_to(10'h64);
    pulse_source_model_inst.step_to(10'h63);
    pulse_source_model_inst.step_to(10'h64);
    tick(2);
    chk_s(tout_status_o, tout_hit);
    chk_v(result_o, 32'h12345678);
    // Combined: interval failure alone suffices
    wr(`OFS_TOUT, 32'h5);
    pulse_source_model_inst.pulse(3, 1'b1);
    tick(3 * MS);
    chk_s(tout_status_o, tout_hit);
    wr(`OFS_TOUT, 32'h0);
    tick(2);
    chk_s(tout_status_o, tout_inactive);
    wr(`OFS_CFG, 32'hff000301);
    tick(2);
    chk_v(result_o, `NO_MEAS_VALUE);
    final_report;
  end
endmodule : test_pulse_measure_channel_config
`default_nettype wire
